// file: verification/dpx_channel_model.sv
/*
 * Channel model: sends one write byte with its parity bit under
 * service out, then gives the write clock phase strobes.
 * Assumes go is a one-cycle pulse synchronous to pclk.
 */
`timescale 1ns/1ps
module dpx_channel_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       go,
   input  wire logic [7:0] byte_in,
   input  wire logic       par_in,
   output logic            service_out,
   output logic            service_out_dly,
   output logic [7:0]      bus_out,
   output logic            bus_out_parity,
   output logic            write_phase_three,
   output logic            write_phase_seven,
   output logic            done
);
   logic [3:0] step_r;
   logic [8:0] last_r;
   // Step through one byte transfer per go request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_r <= 4'h0;
      end else if (go) begin
         step_r <= 4'h1;
      end else if (step_r != 4'h0) begin
         step_r <= (step_r == 4'h8) ? 4'h0 : step_r + 4'h1;
      end
   end
   // Capture byte and parity bit for the transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_r <= 9'h000;
      end else if (go) begin
         last_r <= {par_in, byte_in};
      end
   end
   // Tag, its delayed copy and the phase strobes
   assign service_out       = (step_r == 4'h1) || (step_r == 4'h2);
   assign service_out_dly   = (step_r == 4'h2) || (step_r == 4'h3);
   assign write_phase_three = (step_r == 4'h5);
   assign write_phase_seven = (step_r == 4'h7);
   assign done              = (step_r == 4'h8);
   // Byte valid under service out, inverted once released
   assign {bus_out_parity, bus_out} = service_out ? last_r : ~last_r;
endmodule : dpx_channel_model

// file: verification/dpx_cross_check_tb.sv
/*
 * Self-checking bench of the parity cross-check block.
 * Assumes the channel model drives the write tags and bytes.
 */
`timescale 1ns/1ps
module dpx_cross_check_tb;
   import dpx_pkg::*;
   typedef struct {logic [3:0] c; logic [7:0] b; logic p; logic e;} dpx_row_t;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, byte_in = 8'h00, rreg = 8'h00, bo, hreg;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        go = 1'b0, par_in = 1'b0, rmode = 1'b0, rbr = 1'b0, rp23 = 1'b0;
   logic        boc = 1'b0, derr = 1'b0, ncmd = 1'b0, serr, pready, pslverr;
   logic        so, sod, bop, wp3, wp7, done, xerr, uchk, irq;
   int          fail_count = 0, check_count = 0;
   logic [31:0] sm = (32'h1 << SNS_XCHK) | (32'h1 << SNS_EQUIP_CHECK);
   logic [31:0] im = (32'h1 << INT_XCHK) | (32'h1 << INT_UNIT_CHECK);
   dpx_row_t    rows [14] = '{'{4'h0, 8'h01, 1'b0, 1'b0}, '{4'h0, 8'h01, 1'b1, 1'b1},
      '{4'h0, 8'h03, 1'b1, 1'b0}, '{4'h0, 8'h03, 1'b0, 1'b1}, '{4'h0, 8'hFF, 1'b1, 1'b0},
      '{4'h0, 8'h00, 1'b0, 1'b1}, '{4'h1, 8'h1C, 1'b0, 1'b0}, '{4'h1, 8'h18, 1'b0, 1'b1},
      '{4'h3, 8'h1C, 1'b1, 1'b0}, '{4'h3, 8'h1C, 1'b0, 1'b1}, '{4'h5, 8'h81, 1'b1, 1'b0},
      '{4'h5, 8'h80, 1'b1, 1'b1}, '{4'h1, 8'h1D, 1'b1, 1'b0}, '{4'h1, 8'h1D, 1'b0, 1'b1}};
   // ****************************************************************
   // Clock, design and channel model
   // ****************************************************************
   initial forever #10 pclk = ~pclk;
   dpx_cross_check i_dpx_cross_check (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .read_mode(rmode), .read_byte_ready(rbr),
      .read_register(rreg), .read_phase_two_three(rp23), .service_out(so),
      .service_out_dly(sod), .bus_out(bo), .bus_out_parity(bop), .write_phase_three(wp3),
      .write_phase_seven(wp7), .bus_out_check(boc), .data_error(derr), .new_command(ncmd),
      .holding_register(hreg), .xchk_error(xerr), .unit_check(uchk), .irq(irq));
   dpx_channel_model i_dpx_channel_model (.pclk(pclk), .presetn(presetn), .go(go),
      .byte_in(byte_in), .par_in(par_in), .service_out(so), .service_out_dly(sod),
      .bus_out(bo), .bus_out_parity(bop), .write_phase_three(wp3),
      .write_phase_seven(wp7), .done(done));
   // Verdict and end of run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // Compare one value
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Bounded wait failure
   task automatic hang;
      fail_count++;
      end_of_test();
   endtask : hang
   // One APB transfer, setup then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang();
      rdata = prdata;
      serr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
   endtask : apb
   // New command pulse
   task automatic cmd;
      @(posedge pclk);
      ncmd <= 1'b1;
      @(posedge pclk);
      ncmd <= 1'b0;
      @(posedge pclk);
      #1;
   endtask : cmd
   // One write byte through the channel model
   task automatic send(input logic [7:0] b, input logic p);
      int n;
      @(posedge pclk);
      byte_in <= b;
      par_in  <= p;
      go      <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      for (n = 0; n < 20 && done !== 1'b1; n++) begin
         @(posedge pclk);
         #1;
      end
      if (done !== 1'b1) hang();
      @(posedge pclk);
      #1;
   endtask : send
   // One read byte check
   task automatic rd(input logic [7:0] r);
      @(posedge pclk);
      rreg <= r;
      rbr  <= 1'b1;
      @(posedge pclk);
      rbr  <= 1'b0;
      rp23 <= 1'b1;
      @(posedge pclk);
      rp23 <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
   endtask : rd
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (10) @(posedge pclk);
      #1;
      check("xchk rst", xerr, 32'h0);
      check("irq rst", irq, 32'h0);
      check("pready rst", pready, 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0);
      check("ctrl rst", rdata, {28'h0, CTRL_RST});
      apb(1'b0, OFS_ENABLE, 32'h0);
      check("enable rst", rdata, {30'h0, INT_RST});
      apb(1'b1, 8'h18, 32'h0);
      check("unmapped", serr, 32'h1);
      foreach (rows[i]) begin
         apb(1'b1, OFS_CTRL, {28'h0, rows[i].c});
         cmd();
         send(rows[i].b, rows[i].p);
         check("hold", hreg, rows[i].b);
         check("xchk", xerr, rows[i].e);
         check("uchk", uchk, rows[i].e);
         apb(1'b0, OFS_SENSE, 32'h0);
         check("sense", rdata & sm, rows[i].e ? sm : 32'h0);
      end
      // Precedence errors hold the latch off
      apb(1'b1, OFS_CTRL, 32'h0);
      for (int k = 0; k < 2; k++) begin
         cmd();
         @(posedge pclk);
         boc  <= (k == 0);
         derr <= (k == 1);
         send(8'h01, 1'b1);
         check("prec", xerr, 32'h0);
         @(posedge pclk);
         boc  <= 1'b0;
         derr <= 1'b0;
      end
      // Interrupt raise, clear, mask and sense reset
      apb(1'b1, OFS_ENABLE, 32'h1 << INT_XCHK);
      send(8'h01, 1'b1);
      check("irq", irq, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status", rdata, im);
      apb(1'b1, OFS_CLEAR, im);
      check("irq clr", irq, 32'h0);
      cmd();
      check("xchk cmd", xerr, 32'h0);
      check("uchk cmd", uchk, 32'h0);
      apb(1'b1, OFS_ENABLE, 32'h0);
      send(8'h01, 1'b1);
      check("irq mask", irq, 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status m", rdata, im);
      // Read path compare
      cmd();
      send(8'h01, 1'b0);
      @(posedge pclk);
      rmode <= 1'b1;
      rd(8'h07);
      check("rd same", xerr, 32'h0);
      rd(8'h03);
      check("rd diff", xerr, 32'h1);
      cmd();
      rd(8'h07);
      check("rd next", xerr, 32'h0);
      @(posedge pclk);
      rmode <= 1'b0;
      // Data convert checks every fourth character
      apb(1'b1, OFS_CTRL, 32'h9);
      cmd();
      for (int k = 0; k < 4; k++) begin
         send(8'h04, 1'b1);
         check("conv", xerr, (k == 3));
      end
      // Debug view: one complement left, trap set, group count wrapped
      apb(1'b0, OFS_COUNT, 32'h0);
      check("count", rdata, 32'h7);
      end_of_test();
   end
endmodule : dpx_cross_check_tb

// file: verilog/dpx_cross_check.sv
/*
 * Data path parity cross-check of a tape controller: compares read
 * register parity against holding register parity on reads, and
 * holding register parity against the trapped bus-out parity bit on
 * writes; reports failures through sense bits and unit check.
 * Assumes clock phase strobes and data paths come from the controller
 * logic synchronous to pclk; registers are reached over APB.
 */
// Added by the designer: the register addresses and register access over APB.
// Overview of operation
// - Bus-out parity or data errors hold the cross-check latch reset.
// - Read: odd one count in read register bits 0-7 sets parity_toggle.
// - Holding register odd byte complements toggle; still set at phase two-three sets error.
// - Read error is the exclusive-OR of the two parity outputs.
// - Service out loads byte into holding register and parity bit into trap.
// - Delayed service out without service out: complement toggle on odd byte.
// - At write phase three complement toggle if trap latch is empty.
// - Strobe at write phase seven sets error only after exactly one complement.
// - Seven-track non-translate uses parity bit with lines 0 and 1.
// - A one on line 0 or 1 adjusts expected parity to lines 2-7.
// - Nine-track or convert: parity bit alone, present means 0-7 even.
// - Data convert option checks once per four characters.
// - Error sets sense 3 bit 7, sense 0 bit 3, and unit check.
// - Nine-track correct parity is odd; seven-track follows mode setting.
// - New command sense reset clears all sense and error latches unless set_err or suppress is active.
`timescale 1ns/1ps
module dpx_cross_check (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        read_mode,
   input  wire logic        read_byte_ready,
   input  wire logic [7:0]  read_register,
   input  wire logic        read_phase_two_three,
   input  wire logic        service_out,
   input  wire logic        service_out_dly,
   input  wire logic [7:0]  bus_out,
   input  wire logic        bus_out_parity,
   input  wire logic        write_phase_three,
   input  wire logic        write_phase_seven,
   input  wire logic        bus_out_check,
   input  wire logic        data_error,
   input  wire logic        new_command,
   output logic [7:0]       holding_register,
   output logic             xchk_error,
   output logic             unit_check,
   output logic             irq
);
   import dpx_pkg::*;

   // ****************************************************************
   // Parity helper
   // ****************************************************************
   // Odd one count of a byte
   function automatic logic odd_byte(input logic [7:0] b);
      return ^b;
   endfunction : odd_byte

   logic [3:0]  ctrl_r;
   logic        toggle_r;
   logic        trap_r;
   logic [1:0]  cmpl_cnt_r;
   logic [1:0]  conv_cnt_r;
   logic        xchk_r;
   logic        equip_r;
   logic [1:0]  int_sts_r;
   logic [1:0]  int_en_r;
   logic        suppress;
   logic        write_ok_odd;
   logic        exp_even;
   logic        group_done;
   logic        set_err;
   logic        rd_err;
   logic        wr_err;
   logic        apb_wr;
   logic        apb_rd;
   logic [1:0]  clr_bits;

   assign apb_wr   = psel && penable && pwrite;
   assign apb_rd   = psel && !penable && !pwrite;
   assign suppress = bus_out_check || data_error;

   // ****************************************************************
   // Write expected parity
   // ****************************************************************
   // Parity bit present means the checked lines are even; seven-track
   // non-translate excludes lines 0 and 1 from the checked field
   always_comb begin
      exp_even = trap_r;
      if (ctrl_r[CTRL_SEVEN_TRACK] && !ctrl_r[CTRL_TRANSLATE]) begin
         exp_even = trap_r ^ holding_register[0] ^ holding_register[1];
      end
      // Even-parity seven-track mode inverts what a parity bit means
      write_ok_odd = exp_even ^ (ctrl_r[CTRL_SEVEN_TRACK] && ctrl_r[CTRL_EVEN_PARITY]);
   end

   // Odd count of the data bits actually sent to the drive
   logic data_odd;
   always_comb begin
      if (ctrl_r[CTRL_SEVEN_TRACK] && !ctrl_r[CTRL_TRANSLATE]) begin
         data_odd = odd_byte({2'h0, holding_register[7:2]});
      end else begin
         data_odd = odd_byte(holding_register);
      end
   end

   // ****************************************************************
   // Holding register and parity trap
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         holding_register <= 8'h00;
         trap_r           <= 1'b0;
      end else if (service_out && !service_out_dly) begin
         holding_register <= bus_out;
         trap_r           <= bus_out_parity;
      end
   end

   // ****************************************************************
   // Parity toggle
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle_r   <= 1'b0;
         cmpl_cnt_r <= 2'h0;
      end else if (read_mode) begin
         if (read_byte_ready) begin
            // Toggle set by read register, complemented by holding register
            toggle_r <= odd_byte(read_register) ^ odd_byte(holding_register);
         end else if (read_phase_two_three) begin
            toggle_r <= 1'b0;
         end
      end else begin
         if (service_out && !service_out_dly) begin
            toggle_r   <= 1'b0;
            cmpl_cnt_r <= 2'h0;
         end else if (service_out_dly && !service_out) begin
            if (data_odd) begin
               toggle_r   <= !toggle_r;
               cmpl_cnt_r <= cmpl_cnt_r + 2'h1;
            end
         end else if (write_phase_three && !write_ok_odd) begin
            toggle_r   <= !toggle_r;
            cmpl_cnt_r <= cmpl_cnt_r + 2'h1;
         end
      end
   end

   // ****************************************************************
   // Data convert grouping
   // ****************************************************************
   // Only the fourth character of a group is strobed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_cnt_r <= 2'h0;
      end else if (new_command) begin
         conv_cnt_r <= 2'h0;
      end else if ((read_mode && read_phase_two_three) || (!read_mode && write_phase_seven)) begin
         conv_cnt_r <= conv_cnt_r + 2'h1;
      end
   end
   assign group_done = !ctrl_r[CTRL_DATA_CONV] || (conv_cnt_r == CONV_GROUP_LAST);

   // Error requests from the read and write strobes
   assign rd_err  = read_mode && read_phase_two_three && toggle_r;
   assign wr_err  = !read_mode && write_phase_seven && toggle_r
                    && (cmpl_cnt_r == 2'h1);
   assign set_err = (rd_err || wr_err) && group_done && !suppress;

   // ****************************************************************
   // Error and sense latches
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xchk_r     <= 1'b0;
         equip_r    <= 1'b0;
         unit_check <= 1'b0;
      end else if (suppress) begin
         xchk_r     <= 1'b0;
         unit_check <= unit_check;
      end else if (set_err) begin
         xchk_r     <= 1'b1;
         equip_r    <= 1'b1;
         unit_check <= 1'b1;
      end else if (new_command) begin
         xchk_r     <= 1'b0;
         equip_r    <= 1'b0;
         unit_check <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xchk_error <= 1'b0;
      end else begin
         xchk_error <= set_err || (xchk_r && !new_command && !suppress);
      end
   end

   // ****************************************************************
   // Interrupt status and enable
   // ****************************************************************
   // Clear request from a write to the clear register
   assign clr_bits = (apb_wr && paddr == OFS_CLEAR) ? pwdata[1:0] : 2'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_sts_r <= INT_RST;
         int_en_r  <= INT_RST;
         irq       <= 1'b0;
      end else begin
         // Set wins over clear
         int_sts_r <= (int_sts_r & ~clr_bits) | {set_err, set_err};
         if (apb_wr && paddr == OFS_ENABLE) begin
            int_en_r <= pwdata[1:0];
         end
         irq <= |(((int_sts_r & ~clr_bits) | {set_err, set_err}) & int_en_r);
      end
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
      end else if (apb_wr && paddr == OFS_CTRL) begin
         ctrl_r <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (apb_rd) begin
            unique case (paddr)
               OFS_CTRL:   prdata <= {28'h0, ctrl_r};
               OFS_SENSE:  prdata <= {16'h0, xchk_r, 11'h0, equip_r, 3'h0};
               OFS_STATUS: prdata <= {30'h0, int_sts_r};
               OFS_ENABLE: prdata <= {30'h0, int_en_r};
               OFS_COUNT:  prdata <= {26'h0, conv_cnt_r, cmpl_cnt_r, trap_r, toggle_r};
               OFS_CLEAR:  prdata <= 32'h0000_0000;
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end else if (psel && !penable && pwrite) begin
            pslverr <= !(paddr inside {OFS_CTRL, OFS_CLEAR, OFS_ENABLE});
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Live write strobe after exactly one complement of the toggle
   sequence s_write_one_cmpl;
      !read_mode && write_phase_seven && cmpl_cnt_r == 2'h1 && group_done && !suppress;
   endsequence
   a_suppress_holds: assert property (@(posedge pclk) disable iff (!presetn)
      suppress |=> !xchk_r) else $error("cross-check set under precedence error");
   a_read_error_sets: assert property (@(posedge pclk) disable iff (!presetn)
      rd_err && group_done && !suppress |=> xchk_r && unit_check)
      else $error("read mismatch did not set error");
   a_write_error_sets: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_one_cmpl |=> xchk_r && equip_r && unit_check)
      else $error("write mismatch did not set error");
   a_write_twice_ok: assert property (@(posedge pclk) disable iff (!presetn)
      !read_mode && write_phase_seven && cmpl_cnt_r != 2'h1 && !xchk_r |=> !xchk_r)
      else $error("write strobe not blocked");
   a_sense_reset: assert property (@(posedge pclk) disable iff (!presetn)
      new_command && !set_err && !suppress |=> !xchk_r && !equip_r && !unit_check)
      else $error("sense reset failed");
   a_sense_pair: assert property (@(posedge pclk) disable iff (!presetn)
      xchk_r |-> equip_r && unit_check) else $error("sense bits inconsistent");
   a_load_trap: assert property (@(posedge pclk) disable iff (!presetn)
      service_out && !service_out_dly |=> holding_register == $past(bus_out)
      && trap_r == $past(bus_out_parity)) else $error("holding load failed");
   a_toggle_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !read_mode && service_out && !service_out_dly |=> !toggle_r && cmpl_cnt_r == 2'h0)
      else $error("toggle not cleared");
   a_read_xor: assert property (@(posedge pclk) disable iff (!presetn)
      read_mode && read_byte_ready
      |=> toggle_r == ((^$past(read_register)) ^ (^$past(holding_register))))
      else $error("read compare wrong");
   a_wc3_comp: assert property (@(posedge pclk) disable iff (!presetn)
      !read_mode && write_phase_three && !write_ok_odd && !service_out && !service_out_dly
      |=> toggle_r != $past(toggle_r)) else $error("phase three complement missed");
endmodule : dpx_cross_check

// file: verilog/dpx_pkg.sv
/*
 * Package for the data path parity cross-check block: register map,
 * field positions, reset values and mode codes.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package dpx_pkg;
   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SENSE   = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_CLEAR   = 8'h0C;
   localparam logic [7:0] OFS_ENABLE  = 8'h10;
   localparam logic [7:0] OFS_COUNT   = 8'h14;
   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTRL_SEVEN_TRACK = 0;   // Seven-track drive
   localparam int CTRL_EVEN_PARITY = 1;   // Seven-track even parity mode
   localparam int CTRL_TRANSLATE   = 2;   // Seven-track convert (translate)
   localparam int CTRL_DATA_CONV   = 3;   // Data convert option
   localparam logic [3:0] CTRL_RST = 4'h0;
   // ****************************************************************
   // Sense / status fields
   // ****************************************************************
   localparam int SNS_EQUIP_CHECK = 3;    // Sense byte 0 bit 3
   localparam int SNS_XCHK        = 8 + 7; // Sense byte 3 bit 7 (in low half)
   localparam int STS_UNIT_CHECK  = 0;
   localparam int INT_XCHK        = 0;    // Interrupt event bits
   localparam int INT_UNIT_CHECK  = 1;
   localparam logic [1:0] INT_RST = 2'h0;
   localparam logic [1:0] CONV_GROUP_LAST = 2'h3; // Four characters a group
endpackage : dpx_pkg
